// ### inc/fwp_regs.svh
// Constants of the flash write-protect and instruction-framing link.
`ifndef FWP_REGS_SVH
`define FWP_REGS_SVH

// Clock rate and timing; power-up and write times in nanoseconds, the host half period in reference cycles.
`define FWP_REF_MHZ 200
`define FWP_PUW_NS 10000
`define FWP_WRITE_NS 2000
`define FWP_HOST_HALF 4

// Instruction codes.
`define FWP_OP_LATCH_SET 8'h06
`define FWP_OP_LATCH_CLR 8'h04
`define FWP_OP_STATUS_FETCH 8'h05
`define FWP_OP_STATUS_WRITE 8'h01
`define FWP_OP_PAGE_PROGRAM 8'h02
`define FWP_OP_FOUR_KB_CLEAR 8'h20
`define FWP_OP_HALF_BLOCK_WIPE 8'h52
`define FWP_OP_BLOCK_WIPE 8'hd8
`define FWP_OP_FULL_WIPE 8'hc7
`define FWP_OP_SLEEP_ENTER 8'hb9
`define FWP_OP_WAKE 8'hab
`define FWP_OP_READ 8'h03

// Sequence lengths in bytes, and the bit counts where status and data out begin.
`define FWP_WAKE_MIN_BYTES 9'h001
`define FWP_STATUS_WRITE_MIN_BYTES 9'h002
`define FWP_ADDR_BYTES 9'h004
`define FWP_PROG_MIN_BYTES 9'h005
`define FWP_STATUS_OUT_START 12'h008
`define FWP_DATA_OUT_START 12'h020

// Status byte field positions.
`define FWP_ST_BUSY 0
`define FWP_ST_LATCH 1
`define FWP_ST_LEVEL_LO 2
`define FWP_ST_LEVEL_HI 5
`define FWP_ST_PIN_OFF 6
`define FWP_ST_LOCK 7

// Reset values of the non-volatile bits.
`define FWP_LEVEL_RESET 4'h0
`define FWP_LOCK_RESET 1'b0
`define FWP_PIN_OFF_RESET 1'b0

// Identifier byte shifted out by the wake instruction; the value is arbitrary.
`define FWP_IDENT 8'h5a

`endif

// ### inc/fwp_pkg.sv
// Types of the flash framing link: host states for the host end, array operation kinds for the device end.
package fwp_pkg;
	typedef enum logic [2:0] {
		fwp_kind_program     = 3'b000,
		fwp_kind_sector      = 3'b001,
		fwp_kind_half_block  = 3'b010,
		fwp_kind_block       = 3'b011,
		fwp_kind_full        = 3'b100,
		fwp_kind_status      = 3'b101
	} fwp_kind_type;

	typedef enum logic [1:0] {
		fwp_host_idle  = 2'b00,
		fwp_host_shift = 2'b01,
		fwp_host_end   = 2'b10,
		fwp_host_gap   = 2'b11
	} fwp_host_state_type;
endpackage

// ### inc/fwp_link_if.sv
// Serial link between the host controller and the flash device.
`timescale 1ns/1ps
interface fwp_link_if;
	logic sclk;
	logic sel_n;
	logic serial_in;
	logic serial_out;
	logic protect_n;

	modport host (
		output sclk,
		output sel_n,
		output serial_in,
		output protect_n,
		input  serial_out
	);

	modport device (
		input  sclk,
		input  sel_n,
		input  serial_in,
		input  protect_n,
		output serial_out
	);
endinterface

// ### verilog/fwp_sync.sv
// Two-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
module fwp_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // fwp_sync

// ### verilog/fwp_host.sv
// Host end: frames instructions onto the serial link from the reference clock.
`timescale 1ns/1ps
`include "fwp_regs.svh"
module fwp_host (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Link
	fwp_link_if.host         link,
	// Request
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [11:0] req_bits,
	input  wire logic [39:0] req_word,
	input  wire logic        protect_pin_n,
	// Answer
	output logic             rsp_valid,
	output logic [7:0]       rsp_byte,
	output logic             done
);
	localparam logic [3:0] HALF = 4'(`FWP_HOST_HALF);

	fwp_pkg::fwp_host_state_type state;
	logic [3:0]  div;
	logic [11:0] sent;
	logic [11:0] total;
	logic [39:0] word;
	logic [7:0]  rep;
	logic [7:0]  rx;
	logic        so_s;
	logic        sclk_q;
	logic        sel_q;

	fwp_sync #(.W(1)) u_so_sync (
		.clk   (ref_clk),
		.reset (reset),
		.d     (link.serial_out),
		.q     (so_s)
	);

	assign req_ready      = (state == fwp_pkg::fwp_host_idle);
	assign link.sclk      = sclk_q;
	assign link.sel_n     = sel_q;
	assign link.serial_in = word[39]; // R10
	assign link.protect_n = protect_pin_n;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state     <= fwp_pkg::fwp_host_idle;
			div       <= 4'h0;
			sent      <= 12'h000;
			total     <= 12'h000;
			word      <= 40'h00_0000_0000;
			rep       <= 8'h00;
			rx        <= 8'h00;
			sclk_q    <= 1'b0;
			sel_q     <= 1'b1;
			rsp_valid <= 1'b0;
			rsp_byte  <= 8'h00;
			done      <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			done      <= 1'b0;
			unique case (state)
				fwp_pkg::fwp_host_idle: begin
					if (req_valid && req_bits != 12'h000) begin
						word  <= req_word;
						rep   <= req_word[7:0];
						total <= req_bits;
						sent  <= 12'h000;
						div   <= 4'h0;
						sel_q <= 1'b0;
						state <= fwp_pkg::fwp_host_shift;
					end
				end
				fwp_pkg::fwp_host_shift: begin
					div <= div + 4'h1;
					if (div == HALF - 4'h1) begin
						sclk_q <= 1'b1;
						sent   <= sent + 12'h001;
						rx     <= {rx[6:0], so_s};
						if (sent[2:0] == 3'h7) begin
							rsp_valid <= 1'b1;
							rsp_byte  <= {rx[6:0], so_s};
						end
					end else if (div == 2 * HALF - 4'h1) begin
						sclk_q <= 1'b0;
						div    <= 4'h0;
						if (sent == total) begin
							state <= fwp_pkg::fwp_host_end; // R13
						end else begin
							word <= {word[38:0], rep[7]};
							rep  <= {rep[6:0], rep[7]};
						end
					end
				end
				fwp_pkg::fwp_host_end: begin
					div <= div + 4'h1;
					if (div == HALF - 4'h1) begin
						sel_q <= 1'b1; // R14
						div   <= 4'h0;
						state <= fwp_pkg::fwp_host_gap;
					end
				end
				fwp_pkg::fwp_host_gap: begin
					div <= div + 4'h1;
					if (div == 2 * HALF - 4'h1) begin
						done  <= 1'b1;
						state <= fwp_pkg::fwp_host_idle;
					end
				end
			endcase
		end
	end
endmodule // fwp_host

// ### verilog/fwp_device.sv
// Device end: instruction framing, write latch, block protection and sleep.
`timescale 1ns/1ps
`include "fwp_regs.svh"
// Summary of operation
// (R1) Power-up timer blocks modifying instructions.
// (R2) Modifying instructions need the write latch set.
// (R3) Latch clears at reset and modify completion.
// (R4) Protect level selects protected low region.
// (R5) Wipes touching protected regions are refused.
// (R6) Low-level codes refuse last block wipes; the code allows them at codes 4 to 6.
// (R7) High-level codes refuse first block wipes.
// (R8) Protect pin guards level and lock bits.
// (R9) Deep sleep honours only the wake instruction.
// (R10) All fields travel most significant bit first.
// (R11) First bit sampled on first rising edge.
// (R12) Sequence begins with one instruction byte.
// (R13) Host raises select after final input bit.
// (R14) Data out ends wherever select rises.
// (R15) Modifying instructions need whole-byte frames.
// (R16) Partial program byte leaves latch set.
// (R17) Program and wake need minimum byte counts.
// (R18) Sector and block wipes need exact address.
// (R19) Busy cycle ignores array access attempts.
// (R20) Pin protection makes lock and level read-only.
// (R21) Pin-protect-off bit disables the protect pin.
// (R22) Program or erase into protection is ignored.
module fwp_device (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        reset,
	// Link
	fwp_link_if.device       link,
	// Array side
	input  wire logic [7:0]  array_rdata,
	output logic             array_op_valid,
	output fwp_pkg::fwp_kind_type array_op_kind,
	output logic [23:0]      array_op_addr,
	output logic [7:0]       array_op_data,
	// State
	output logic [7:0]       status,
	output logic             asleep
);
	localparam int PUW_CYC = `FWP_PUW_NS * `FWP_REF_MHZ / 1000;
	localparam int WRITE_CYC = `FWP_WRITE_NS * `FWP_REF_MHZ / 1000;

	// Link-domain frame capture.
	logic        frame_clr;
	logic        frame_fresh;
	logic [11:0] bit_count;
	logic [11:0] cnt_next;
	logic [7:0]  shreg;
	logic [7:0]  in_byte;
	logic [7:0]  opc;
	logic [23:0] addr;
	logic [7:0]  data0;
	logic [7:0]  pdata;
	logic [16:0] slow_s;
	logic        out_en;
	logic [7:0]  out_byte;
	logic        so_q;

	// Core-domain state.
	logic [1:0]  pin_s;
	logic        sel_d;
	logic        frame_end;
	logic [15:0] puw_cnt;
	logic        puw_done;
	logic [15:0] busy_cnt;
	logic        busy;
	logic        write_latch;
	logic [3:0]  protect_level;
	logic        status_lock;
	logic        pin_protect_off;
	logic        pin_protection;
	logic [8:0]  nbytes;
	logic        whole;
	logic        armed;
	logic [7:0]  start_sector;
	logic        hits_protect;

	function automatic logic [8:0] fwp_limit(input logic [3:0] lv);
		case (lv)
			4'h1:    fwp_limit = 9'h0fe;
			4'h2:    fwp_limit = 9'h0fc;
			4'h3:    fwp_limit = 9'h0f8;
			4'h4:    fwp_limit = 9'h0f0;
			4'h5:    fwp_limit = 9'h0e0;
			4'h6:    fwp_limit = 9'h0c0;
			4'h7:    fwp_limit = 9'h100;
			4'h9:    fwp_limit = 9'h002;
			4'ha:    fwp_limit = 9'h004;
			4'hb:    fwp_limit = 9'h008;
			4'hc:    fwp_limit = 9'h010;
			4'hd:    fwp_limit = 9'h020;
			4'he:    fwp_limit = 9'h040;
			4'hf:    fwp_limit = 9'h100;
			default: fwp_limit = 9'h000;
		endcase
	endfunction

	// The frame fields stay frozen once select rises because the clock stops, so the
	// core may read them after its synchronised view of select has risen.
	assign frame_clr = reset | link.sel_n;
	assign cnt_next  = frame_fresh ? 12'h001 :
		(bit_count == 12'hfff ? bit_count : bit_count + 12'h001);
	assign in_byte   = {shreg[6:0], link.serial_in}; // R10

	always_ff @(posedge link.sclk or posedge frame_clr) begin
		if (frame_clr) begin
			frame_fresh <= 1'b1;
		end else begin
			frame_fresh <= 1'b0;
		end
	end

	always_ff @(posedge link.sclk or posedge reset) begin
		if (reset) begin
			bit_count <= 12'h000;
			shreg     <= 8'h00;
			opc       <= 8'h00;
			addr      <= 24'h00_0000;
			data0     <= 8'h00;
			pdata     <= 8'h00;
		end else begin
			bit_count <= cnt_next; // R11
			shreg     <= in_byte;
			if (cnt_next == 12'h008) begin
				opc <= in_byte; // R12
			end
			if (cnt_next == 12'h010 || cnt_next == 12'h018 || cnt_next == 12'h020) begin
				addr <= {addr[15:0], in_byte};
			end
			if (cnt_next == 12'h010) begin
				data0 <= in_byte;
			end
			if (cnt_next == 12'h028) begin
				pdata <= in_byte;
			end
		end
	end

	fwp_sync #(.W(17)) u_slow_sync (
		.clk   (link.sclk),
		.reset (reset),
		.d     ({asleep, status, array_rdata}),
		.q     (slow_s)
	);

	always_comb begin
		out_en   = 1'b0;
		out_byte = slow_s[15:8];
		if (opc == `FWP_OP_WAKE && bit_count >= `FWP_DATA_OUT_START) begin
			out_en   = 1'b1;
			out_byte = `FWP_IDENT;
		end else if (!slow_s[16]) begin // R9
			if (opc == `FWP_OP_STATUS_FETCH && bit_count >= `FWP_STATUS_OUT_START) begin
				out_en = 1'b1;
			end else if (opc == `FWP_OP_READ && bit_count >= `FWP_DATA_OUT_START
				&& !slow_s[8 + `FWP_ST_BUSY]) begin // R19
				out_en   = 1'b1;
				out_byte = slow_s[7:0];
			end
		end
	end

	// Data changes on the falling edge so the host samples it settled on the rise.
	// Cleared while deselected so the line never keeps the last data bit between frames.
	always_ff @(negedge link.sclk or posedge frame_clr) begin
		if (frame_clr) begin
			so_q <= 1'b0;
		end else begin
			so_q <= out_en ? out_byte[~bit_count[2:0]] : 1'b0; // R10 R14
		end
	end

	assign link.serial_out = so_q;

	fwp_sync #(.W(2)) u_pin_sync (
		.clk   (ref_clk),
		.reset (reset),
		.d     ({~link.protect_n, ~link.sel_n}),
		.q     (pin_s)
	);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sel_d <= 1'b0;
		end else begin
			sel_d <= pin_s[0];
		end
	end

	// The pins are synchronised inverted, so the cleared flops match the idle pins and no
	// false frame end follows reset.
	assign frame_end      = ~pin_s[0] & sel_d;
	assign nbytes         = bit_count[11:3];
	assign whole          = (bit_count[2:0] == 3'h0) && (bit_count != 12'h000); // R15 R16
	assign armed          = write_latch && puw_done && !busy; // R1 R2 R19
	assign pin_protection = status_lock && pin_s[1] && !pin_protect_off; // R8 R21
	assign status         = {status_lock, pin_protect_off, protect_level, write_latch, busy};

	always_comb begin
		unique case (opc)
			`FWP_OP_HALF_BLOCK_WIPE: start_sector = {addr[19:15], 3'h0};
			`FWP_OP_BLOCK_WIPE:      start_sector = {addr[19:16], 4'h0};
			`FWP_OP_FULL_WIPE:       start_sector = 8'h00;
			default:                 start_sector = addr[19:12];
		endcase
		hits_protect = ({1'b0, start_sector} < fwp_limit(protect_level)); // R4 R5 R6 R7 R22
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			puw_cnt  <= 16'h0000;
			puw_done <= 1'b0;
		end else if (!puw_done) begin
			puw_cnt  <= puw_cnt + 16'h0001;
			puw_done <= (puw_cnt == 16'(PUW_CYC - 1)); // R1
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_cnt <= 16'h0000;
		end else if (array_op_valid) begin
			busy_cnt <= 16'(WRITE_CYC);
		end else if (busy_cnt != 16'h0000) begin
			busy_cnt <= busy_cnt - 16'h0001;
		end
	end

	assign busy = (busy_cnt != 16'h0000);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			write_latch     <= 1'b0; // R3
			protect_level   <= `FWP_LEVEL_RESET;
			status_lock     <= `FWP_LOCK_RESET;
			pin_protect_off <= `FWP_PIN_OFF_RESET;
			asleep          <= 1'b0;
			array_op_valid  <= 1'b0;
			array_op_kind   <= fwp_pkg::fwp_kind_program;
			array_op_addr   <= 24'h00_0000;
			array_op_data   <= 8'h00;
		end else begin
			array_op_valid <= 1'b0;
			if (frame_end && asleep) begin
				if (opc == `FWP_OP_WAKE && nbytes >= `FWP_WAKE_MIN_BYTES) begin
					asleep <= 1'b0; // R9 R17
				end
			end else if (frame_end && whole && !busy) begin
				array_op_addr <= addr;
				unique case (opc)
					`FWP_OP_LATCH_SET: begin
						write_latch <= puw_done; // R2
					end
					`FWP_OP_LATCH_CLR: begin
						write_latch <= 1'b0; // R3
					end
					`FWP_OP_SLEEP_ENTER: begin
						asleep <= 1'b1;
					end
					`FWP_OP_STATUS_WRITE: begin
						if (armed && nbytes >= `FWP_STATUS_WRITE_MIN_BYTES) begin
							write_latch    <= 1'b0; // R3
							array_op_valid <= 1'b1;
							array_op_kind  <= fwp_pkg::fwp_kind_status;
							array_op_data  <= data0;
							if (!pin_protection) begin // R20
								protect_level   <= data0[`FWP_ST_LEVEL_HI:`FWP_ST_LEVEL_LO];
								status_lock     <= data0[`FWP_ST_LOCK];
								pin_protect_off <= data0[`FWP_ST_PIN_OFF];
							end
						end
					end
					`FWP_OP_PAGE_PROGRAM: begin
						if (armed && nbytes >= `FWP_PROG_MIN_BYTES && !hits_protect) begin // R17
							write_latch    <= 1'b0; // R3
							array_op_valid <= 1'b1;
							array_op_kind  <= fwp_pkg::fwp_kind_program;
							array_op_data  <= pdata;
						end
					end
					`FWP_OP_FOUR_KB_CLEAR, `FWP_OP_HALF_BLOCK_WIPE, `FWP_OP_BLOCK_WIPE: begin
						if (armed && nbytes == `FWP_ADDR_BYTES && !hits_protect) begin // R18
							write_latch    <= 1'b0; // R3
							array_op_valid <= 1'b1;
							array_op_data  <= 8'h00;
							array_op_kind  <= (opc == `FWP_OP_FOUR_KB_CLEAR) ?
								fwp_pkg::fwp_kind_sector :
								(opc == `FWP_OP_BLOCK_WIPE) ? fwp_pkg::fwp_kind_block :
								fwp_pkg::fwp_kind_half_block;
						end
					end
					`FWP_OP_FULL_WIPE: begin
						if (armed && !hits_protect) begin
							write_latch    <= 1'b0; // R3
							array_op_valid <= 1'b1;
							array_op_kind  <= fwp_pkg::fwp_kind_full;
							array_op_data  <= 8'h00;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule // fwp_device

// ### tb/fwp_properties.sv
// Checker of the framing seen on the serial link between the two ends.
`timescale 1ns/1ps
module fwp_properties (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Link
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic protect_n
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_quiet;
		!sclk [*4];
	endsequence

	sequence s_high;
		sclk [*4] ##1 !sclk;
	endsequence

	AST_SCLK_IDLE: assert property (sel_n |-> !sclk)
		else $error("link clock ran while deselected");
	AST_FIRST_BIT: assert property ($fell(sel_n) |-> s_quiet ##1 sclk)
		else $error("first link clock rise misplaced after select");
	AST_SCLK_SHAPE: assert property ($rose(sclk) |-> s_high)
		else $error("link clock high phase has wrong length");
	AST_DATA_HOLD: assert property (!sel_n && sclk |-> $stable(serial_in))
		else $error("serial input moved while link clock high");
	AST_SEL_END: assert property ($rose(sel_n) |-> !$past(sclk) && !$past(sclk, 4))
		else $error("select rose too soon after the last clock fall");
	AST_SEL_GAP: assert property ($rose(sel_n) |-> sel_n [*4])
		else $error("select gap between frames too short");
	AST_OUT_RELEASE: assert property (sel_n [*4] |-> !serial_out)
		else $error("serial output still driven after deselect");
	AST_OUT_EDGE: assert property (!sel_n && !$past(sel_n) && $changed(serial_out) |-> !sclk)
		else $error("serial output changed while link clock high");
endmodule // fwp_properties

// ### tb/flash_write_protect_framing_tb.sv
// Self-checking bench of the host and device ends joined by the link.
`timescale 1ns/1ps
`include "fwp_regs.svh"
module flash_write_protect_framing_tb;
	logic                  ref_clk = 1'b0;
	logic                  reset = 1'b1;
	logic                  req_valid = 1'b0;
	logic                  req_ready;
	logic [11:0]           req_bits = 12'h000;
	logic [39:0]           req_word = 40'h00_0000_0000;
	logic                  protect_pin_n = 1'b1;
	logic                  rsp_valid;
	logic [7:0]            rsp_byte;
	logic                  done;
	logic [7:0]            array_rdata = 8'hc5;
	logic                  array_op_valid;
	fwp_pkg::fwp_kind_type array_op_kind;
	logic [23:0]           array_op_addr;
	logic [7:0]            array_op_data;
	logic [7:0]            status;
	logic                  asleep;
	logic [7:0]            last_rsp = 8'h00;
	int                    n_errors = 0;
	int                    n_compared = 0;
	int                    n_ops = 0;
	// Protected sector limit per level code, and the four wipes tried at each code.
	logic [8:0]            lim [16] = '{9'h000, 9'h0fe, 9'h0fc, 9'h0f8, 9'h0f0, 9'h0e0,
		9'h0c0, 9'h100, 9'h000, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040, 9'h100};
	logic [7:0]            wo [4] = '{`FWP_OP_BLOCK_WIPE, `FWP_OP_HALF_BLOCK_WIPE,
		`FWP_OP_HALF_BLOCK_WIPE, `FWP_OP_FULL_WIPE};
	logic [23:0]           wa [4] = '{24'h0f0000, 24'h0f8000, 24'h000000, 24'h000000};
	logic [8:0]            ws [4] = '{9'h0f0, 9'h0f8, 9'h000, 9'h000};
	logic [11:0]           wb [4] = '{12'h020, 12'h020, 12'h020, 12'h008};

	fwp_link_if link ();

	fwp_host u_fwp_host (.ref_clk(ref_clk), .reset(reset), .link(link),
		.req_valid(req_valid), .req_ready(req_ready), .req_bits(req_bits),
		.req_word(req_word), .protect_pin_n(protect_pin_n), .rsp_valid(rsp_valid),
		.rsp_byte(rsp_byte), .done(done));
	fwp_device u_fwp_device (.ref_clk(ref_clk), .reset(reset), .link(link),
		.array_rdata(array_rdata), .array_op_valid(array_op_valid),
		.array_op_kind(array_op_kind), .array_op_addr(array_op_addr),
		.array_op_data(array_op_data), .status(status), .asleep(asleep));
	fwp_properties u_fwp_properties (.ref_clk(ref_clk), .reset(reset), .sclk(link.sclk),
		.sel_n(link.sel_n), .serial_in(link.serial_in), .serial_out(link.serial_out),
		.protect_n(link.protect_n));

	always #2.5 ref_clk = ~ref_clk;

	// Counted here so that a one-cycle start pulse is never missed by a busy task.
	always @(posedge ref_clk) begin
		if (array_op_valid === 1'b1)
			n_ops++;
		if (rsp_valid === 1'b1)
			last_rsp <= rsp_byte;
	end

	task automatic report_and_stop();
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Entered and left just after a rising edge; the request is held one cycle while idle.
	task automatic xfer(input logic [11:0] bits, input logic [39:0] word);
		int i;
		req_valid <= 1'b1;
		req_bits <= bits;
		req_word <= word;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		for (i = 0; i < 4000 && done !== 1'b1; i++)
			@(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 1000 && status[0] !== 1'b0; i++)
			@(posedge ref_clk);
	endtask

	task automatic latch();
		xfer(12'h008, {`FWP_OP_LATCH_SET, 32'h0});
	endtask

	task automatic sw(input logic [7:0] d);
		latch();
		xfer(12'h010, {`FWP_OP_STATUS_WRITE, d, 24'h0});
		wait_idle();
	endtask

	task automatic t_powerup();
		latch();
		check(status, 8'h00);
		repeat (2000) @(posedge ref_clk);
	endtask

	task automatic t_latch();
		int n;
		n = n_ops;
		xfer(12'h028, {`FWP_OP_PAGE_PROGRAM, 32'h0001_00a5});
		check(n_ops, n);
		check(req_ready, 1'b1);
		xfer(12'h007, {`FWP_OP_LATCH_SET, 32'h0});
		check(status[1], 1'b0);
		latch();
		check(status[1], 1'b1);
		xfer(12'h009, {`FWP_OP_LATCH_CLR, 32'h0});
		check(status[1], 1'b1);
		xfer(12'h008, {`FWP_OP_LATCH_CLR, 32'h0});
		check(status[1], 1'b0);
		latch();
		xfer(12'h010, {`FWP_OP_STATUS_FETCH, 32'h0});
		check(last_rsp, 8'h02);
		xfer(12'h028, {`FWP_OP_READ, 32'h0001_0000});
		check(last_rsp, 8'hc5);
	endtask

	task automatic t_program();
		int n;
		n = n_ops;
		xfer(12'h020, {`FWP_OP_PAGE_PROGRAM, 32'h0123_0000});
		xfer(12'h027, {`FWP_OP_PAGE_PROGRAM, 32'h0123_00a5});
		check(n_ops, n);
		check(status[1], 1'b1);
		xfer(12'h028, {`FWP_OP_PAGE_PROGRAM, 32'h0123_00a5});
		check(n_ops, n + 1);
		check(array_op_addr, 24'h012300);
		check(array_op_data, 8'ha5);
		check(array_op_kind, fwp_pkg::fwp_kind_program);
		check(status[1], 1'b0);
		latch();
		check(status[1], 1'b0);
		wait_idle();
		latch();
		n = n_ops;
		xfer(12'h018, {`FWP_OP_FOUR_KB_CLEAR, 32'h0040_0000});
		xfer(12'h028, {`FWP_OP_FOUR_KB_CLEAR, 32'h0040_0000});
		check(n_ops, n);
		xfer(12'h020, {`FWP_OP_FOUR_KB_CLEAR, 32'h0040_0000});
		check(n_ops, n + 1);
		check(array_op_kind, fwp_pkg::fwp_kind_sector);
		check(array_op_addr, 24'h004000);
		wait_idle();
	endtask

	task automatic t_levels();
		int n;
		for (int c = 0; c < 16; c++) begin
			sw({2'b00, c[3:0], 2'b00});
			check(status[5:1], {c[3:0], 1'b0});
			check(array_op_data, {2'b00, c[3:0], 2'b00});
			for (int k = 0; k < 4; k++) begin
				latch();
				n = n_ops;
				xfer(wb[k], {wo[k], wa[k], 8'h00});
				wait_idle();
				check(n_ops - n, ws[k] >= lim[c]);
			end
		end
	endtask

	task automatic t_pin();
		sw(8'hc8);
		protect_pin_n <= 1'b0;
		sw(8'h94);
		check(status[7:2], 6'h25);
		sw(8'h00);
		check(status[7:2], 6'h25);
		protect_pin_n <= 1'b1;
		sw(8'h00);
		check(status[7:2], 6'h00);
	endtask

	task automatic t_sleep();
		xfer(12'h009, {`FWP_OP_SLEEP_ENTER, 32'h0});
		check(asleep, 1'b0);
		xfer(12'h008, {`FWP_OP_SLEEP_ENTER, 32'h0});
		check(asleep, 1'b1);
		latch();
		check(status[1], 1'b0);
		xfer(12'h028, {`FWP_OP_WAKE, 32'h0});
		check(asleep, 1'b0);
		check(last_rsp, `FWP_IDENT);
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		t_powerup();
		t_latch();
		t_program();
		t_levels();
		t_pin();
		t_sleep();
		report_and_stop();
	end

	// The full run needs roughly 50000 cycles; a hang is cut short well past that.
	initial begin
		repeat (95000) @(posedge ref_clk);
		n_errors++;
		report_and_stop();
	end
endmodule // flash_write_protect_framing_tb
